// ---- cpu_divide_shift_datapath_tb_top.sv ----
// Self-checking testbench of the divide and shift datapath.
`timescale 1ns/1ps
module cpu_divide_shift_datapath_tb_top;
  logic clock;
  logic rstn;
  logic cmd_valid, div_signed, div_long, wr_en, busy, done;
  dsd_pkg::dsd_op_t cmd_op;
  logic [3:0] src_idx, dst_idx, shift_amount, dvs_i, dvd_i, wr_idx, rd_idx;
  logic [15:0] wr_data, rd_data;
  int failures = 0;
  int total_checks = 0;
  int busy_edges = 0;

  // Busy is counted at mid-cycle, where it has settled.
  always @(negedge clock) begin
    if (busy === 1'b1) busy_edges++;
  end

  dsd_datapath dsd_datapath_i (.clock(clock), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .div_signed(div_signed), .div_long(div_long), .src_idx(src_idx),
    .dst_idx(dst_idx), .shift_amount(shift_amount), .divisor_source_register(dvs_i),
    .dividend_register_pair(dvd_i), .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data),
    .rd_idx(rd_idx), .rd_data(rd_data), .busy(busy), .done(done));
  dsd_dec_model dsd_dec_model_i (.clock(clock), .rd_data(rd_data), .done(done),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .div_signed(div_signed), .div_long(div_long),
    .src_idx(src_idx), .dst_idx(dst_idx), .shift_amount(shift_amount),
    .divisor_source_register(dvs_i), .dividend_register_pair(dvd_i), .wr_en(wr_en),
    .wr_idx(wr_idx), .wr_data(wr_data), .rd_idx(rd_idx));

  // ************************************************************
  // Checking and closing
  // ************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs();
    logic [15:0] d;
    dsd_dec_model_i.rd(4'h7, d);
    chk(d, dsd_pkg::REG_RST);
    for (int i = 0; i < 16; i++) dsd_dec_model_i.wr(4'(i), 16'hA500 + 16'(i));
    for (int i = 0; i < 16; i++) begin
      dsd_dec_model_i.rd(4'(i), d);
      chk(d, 16'hA500 + 16'(i));
    end
    $display("test regs done");
  endtask : t_regs
  task automatic t_shift();
    logic [15:0] v, d, e;
    int n;
    logic [3:0] am [4] = '{4'h0, 4'h1, 4'h7, 4'hF};
    int b0;
    v = 16'h9235;
    b0 = busy_edges;
    dsd_dec_model_i.wr(4'h2, v);
    for (int k = 1; k < 4; k++) begin
      for (int j = 0; j < 4; j++) begin
        dsd_dec_model_i.cmd(dsd_pkg::dsd_op_t'(k), 1'b0, 1'b0, 4'h2, am[j], n);
        chk(16'(n), 16'h0000);
        e = (k == 1) ? 16'($signed(v) >>> am[j]) : (k == 2) ? v << am[j] : v >> am[j];
        dsd_dec_model_i.rd(4'h3, d);
        chk(d, e);
        dsd_dec_model_i.rd(4'h2, d);
        chk(d, v);
      end
    end
    chk(16'(busy_edges - b0), 16'h0000);
    $display("test shift done");
  endtask : t_shift
  task automatic t_div(input logic sg, input logic lg, input logic [31:0] x,
                       input logic [15:0] y);
    logic [15:0] d, q, r;
    logic signed [31:0] sx;
    int n;
    int b0;
    sx = lg ? x : (sg ? 32'($signed(x[15:0])) : {16'h0000, x[15:0]});
    q = sg ? 16'(sx / $signed(y)) : 16'(sx / y);
    r = sg ? 16'(sx % $signed(y)) : 16'(sx % y);
    dsd_dec_model_i.wr(4'h4, x[15:0]);
    dsd_dec_model_i.wr(4'h5, x[31:16]);
    dsd_dec_model_i.wr(4'h9, y);
    b0 = busy_edges;
    dsd_dec_model_i.cmd(dsd_pkg::DSD_OP_DIV, sg, lg, lg ? 4'h5 : 4'h4, 4'h0, n);
    chk(16'(n), 16'(dsd_pkg::DIV_ITERS) + 16'h0001);
    chk(16'(busy_edges - b0), 16'(dsd_pkg::DIV_ITERS) + 16'h0001);
    dsd_dec_model_i.rd(dsd_pkg::QUOT_IDX, d);
    chk(d, q);
    dsd_dec_model_i.rd(dsd_pkg::REM_IDX, d);
    chk(d, r);
    $display("test div done");
  endtask : t_div
  // A reset after the divides must clear the quotient and remainder registers and the status outputs.
  task automatic t_reset();
    logic [15:0] d;
    rstn = 1'b0;
    repeat (2) @(posedge clock);
    #1 rstn = 1'b1;
    chk({14'h0000, busy, done}, 16'h0000);
    dsd_dec_model_i.rd(dsd_pkg::QUOT_IDX, d);
    chk(d, dsd_pkg::REG_RST);
    dsd_dec_model_i.rd(dsd_pkg::REM_IDX, d);
    chk(d, dsd_pkg::REG_RST);
    $display("test reset done");
  endtask : t_reset

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // The whole run needs well under two thousand cycles.
  initial begin
    #(25 * 5000);
    failures++;
    end_of_test();
  end
  initial begin
    rstn = 1'b0;
    repeat (8) @(posedge clock);
    #1 rstn = 1'b1;
    t_regs();
    t_shift();
    t_div(1'b0, 1'b1, 32'h00012345, 16'h0100);
    t_div(1'b1, 1'b1, 32'hFFFFF000, 16'h0007);
    t_div(1'b0, 1'b0, 32'h1234FFFF, 16'h0010);
    t_div(1'b1, 1'b0, 32'h00008003, 16'hFFFD);
    t_reset();
    end_of_test();
  end
endmodule : cpu_divide_shift_datapath_tb_top

// ---- dsd_datapath.sv ----
// Divide and multi-bit shift datapath with its working register file.
`timescale 1ns/1ps
module dsd_datapath (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rstn,
  // Command from the decoder
  input  wire logic                 cmd_valid,
  input  wire dsd_pkg::dsd_op_t     cmd_op,
  input  wire logic                 div_signed,
  input  wire logic                 div_long,
  input  wire logic [3:0]           src_idx,
  input  wire logic [3:0]           dst_idx,
  input  wire logic [3:0]           shift_amount,
  input  wire logic [3:0]           divisor_source_register,
  input  wire logic [3:0]           dividend_register_pair,
  // Register file write port from the core
  input  wire logic                 wr_en,
  input  wire logic [3:0]           wr_idx,
  input  wire logic [15:0]          wr_data,
  // Register file read port to the core
  input  wire logic [3:0]           rd_idx,
  output logic      [15:0]          rd_data,
  // Status
  output logic                      busy,
  output logic                      done
);
  // ************************************************************
  // Working register file
  // ************************************************************
  logic [15:0] wreg_r [dsd_pkg::REG_CNT];
  dsd_shift_if sh_bus ();
  dsd_shifter u_shifter (.sh(sh_bus));

  typedef enum logic [1:0] {DSD_IDLE, DSD_ITER, DSD_FIX} dsd_state_t;
  dsd_state_t  state_r;
  logic [31:0] rem_quo_r;   // remainder in high half, quotient bits shift in low
  logic [15:0] dvsr_r;
  logic [4:0]  cnt_r;
  logic        neg_q_r;
  logic        neg_r_r;
  logic        busy_r;
  logic        done_r;
  logic [15:0] rd_data_r;

  function automatic logic [15:0] abs16(input logic [15:0] v, input logic en);
    abs16 = (en && v[15]) ? 16'(-v) : v;
  endfunction : abs16

  // ************************************************************
  // Divider operand capture
  // ************************************************************
  logic [31:0] dvnd_raw;
  logic [31:0] dvnd_abs;
  logic        start_div;
  logic        start_shift;
  logic [16:0] trial;
  logic [31:0] rem_shift;
  assign start_div   = cmd_valid && !busy_r && (cmd_op == dsd_pkg::DSD_OP_DIV);
  assign start_shift = cmd_valid && !busy_r && (cmd_op != dsd_pkg::DSD_OP_DIV)
                       && (cmd_op != dsd_pkg::DSD_OP_NONE);
  // The pair base is forced even; the odd register holds the upper half.
  assign dvnd_raw = div_long ?
    {wreg_r[{dividend_register_pair[3:1], 1'b1}], wreg_r[{dividend_register_pair[3:1], 1'b0}]}
    : (div_signed ? {{16{wreg_r[dividend_register_pair][15]}}, wreg_r[dividend_register_pair]}
                  : {16'h0000, wreg_r[dividend_register_pair]});
  assign dvnd_abs = (div_signed && dvnd_raw[31]) ? 32'(-dvnd_raw) : dvnd_raw;
  // Remainder stays under the divisor, so 16 steps on the high part suffice.
  assign rem_shift = {rem_quo_r[30:0], 1'b0};
  assign trial     = {1'b0, rem_shift[31:16]} - {1'b0, dvsr_r};

  // ************************************************************
  // Shifter hookup
  // ************************************************************
  assign sh_bus.src    = wreg_r[src_idx];
  assign sh_bus.amount = shift_amount;
  assign sh_bus.op     = cmd_op;

  // ************************************************************
  // Divider sequence
  // ************************************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r   <= DSD_IDLE;
      rem_quo_r <= 32'h00000000;
      dvsr_r    <= 16'h0000;
      cnt_r     <= 5'h00;
      neg_q_r   <= 1'b0;
      neg_r_r   <= 1'b0;
    end else begin
      case (state_r)
        DSD_IDLE: begin
          if (start_div) begin
            // Upper dividend half enters unreduced; overflow is not flagged and leaves a wrong, unwrapped quotient.
            rem_quo_r <= dvnd_abs;
            dvsr_r    <= abs16(wreg_r[divisor_source_register], div_signed);
            neg_q_r   <= div_signed &&
                         (dvnd_raw[31] ^ wreg_r[divisor_source_register][15]);
            neg_r_r   <= div_signed && dvnd_raw[31];
            cnt_r     <= dsd_pkg::DIV_ITERS;
            state_r   <= DSD_ITER;
          end
        end
        DSD_ITER: begin
          if (!trial[16] || rem_quo_r[31]) begin
            rem_quo_r <= {16'(rem_shift[31:16] - dvsr_r), rem_shift[15:1], 1'b1};
          end else begin
            rem_quo_r <= rem_shift;
          end
          cnt_r <= 5'(cnt_r - 5'h01);
          if (cnt_r == 5'h01) begin
            state_r <= DSD_FIX;
          end
        end
        DSD_FIX: begin
          state_r <= DSD_IDLE;
        end
        default: begin
          state_r <= DSD_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Register file writes
  // ************************************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < dsd_pkg::REG_CNT; i++) begin
        wreg_r[i] <= dsd_pkg::REG_RST;
      end
    end else begin
      if (state_r == DSD_FIX) begin
        // Sign fix-up happens at write-back to keep the loop short.
        wreg_r[dsd_pkg::QUOT_IDX] <= neg_q_r ? 16'(-rem_quo_r[15:0])
                                             : rem_quo_r[15:0];
        wreg_r[dsd_pkg::REM_IDX]  <= neg_r_r ? 16'(-rem_quo_r[31:16])
                                             : rem_quo_r[31:16];
      end else if (start_shift) begin
        wreg_r[dst_idx] <= sh_bus.result;
      end else if (wr_en && !busy_r) begin
        wreg_r[wr_idx] <= wr_data;
      end
    end
  end

  // ************************************************************
  // Status and read port
  // ************************************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy_r    <= 1'b0;
      done_r    <= 1'b0;
      rd_data_r <= 16'h0000;
    end else begin
      busy_r    <= start_div || (state_r == DSD_ITER) ||
                   (busy_r && state_r != DSD_FIX);
      done_r    <= (state_r == DSD_FIX) || start_shift;
      rd_data_r <= wreg_r[rd_idx];
    end
  end
  assign busy    = busy_r;
  assign done    = done_r;
  assign rd_data = rd_data_r;

  // ************************************************************
  // Checks
  // ************************************************************
  // Run length of the iteration state, so the check does not unroll sixteen repetitions.
  logic [4:0] iter_run_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      iter_run_r <= 5'h00;
    end else if (state_r == DSD_ITER) begin
      iter_run_r <= 5'(iter_run_r + 5'h01);
    end else begin
      iter_run_r <= 5'h00;
    end
  end
  a_div_len_fixed: assert property (@(posedge clock) disable iff (!rstn)
    start_div |-> ##17 (state_r == DSD_FIX) && (iter_run_r == dsd_pkg::DIV_ITERS))
    else $error("Divide did not take sixteen iterations.");
  a_shift_done_next: assert property (@(posedge clock) disable iff (!rstn)
    start_shift |=> done)
    else $error("Shift did not finish in one cycle.");
  a_shift_store: assert property (@(posedge clock) disable iff (!rstn)
    start_shift |=> wreg_r[$past(dst_idx)] == $past(sh_bus.result))
    else $error("Shift result not written to destination.");
  a_asr_sign_fill: assert property (@(posedge clock) disable iff (!rstn)
    (sh_bus.op == dsd_pkg::DSD_OP_ARITH_RIGHT_SHIFT) |->
    sh_bus.result[15] == sh_bus.src[15])
    else $error("Arithmetic right shift lost the sign.");
  a_lsr_zero_fill: assert property (@(posedge clock) disable iff (!rstn)
    (sh_bus.op == dsd_pkg::DSD_OP_LOGICAL_RIGHT_SHIFT) && (sh_bus.amount != 4'h0) |->
    !sh_bus.result[15])
    else $error("Logical right shift did not fill with zero.");
  a_sl_zero_fill: assert property (@(posedge clock) disable iff (!rstn)
    (sh_bus.op == dsd_pkg::DSD_OP_LEFT_SHIFT) && (sh_bus.amount != 4'h0) |->
    !sh_bus.result[0])
    else $error("Left shift did not fill with zero.");
  a_div_writeback: assert property (@(posedge clock) disable iff (!rstn)
    (state_r == DSD_FIX) |=> done && !busy)
    else $error("Divide completion not flagged.");
  a_rem_sign: assert property (@(posedge clock) disable iff (!rstn)
    (state_r == DSD_FIX) && neg_r_r && (rem_quo_r[31:16] != 16'h0000) |=>
    wreg_r[dsd_pkg::REM_IDX][15])
    else $error("Remainder sign differs from dividend.");
  a_busy_during: assert property (@(posedge clock) disable iff (!rstn)
    start_div |=> busy [*8])
    else $error("Divider not busy while iterating.");
endmodule : dsd_datapath

// ---- dsd_dec_model.sv ----
// Behavioural model of the instruction decoder that drives the datapath.
`timescale 1ns/1ps
module dsd_dec_model (
  // Clock and answers from the datapath
  input  wire logic              clock,
  input  wire logic [15:0]       rd_data,
  input  wire logic              done,
  // Commands and register port towards the datapath
  output logic                   cmd_valid,
  output dsd_pkg::dsd_op_t       cmd_op,
  output logic                   div_signed,
  output logic                   div_long,
  output logic [3:0]             src_idx,
  output logic [3:0]             dst_idx,
  output logic [3:0]             shift_amount,
  output logic [3:0]             divisor_source_register,
  output logic [3:0]             dividend_register_pair,
  output logic                   wr_en,
  output logic [3:0]             wr_idx,
  output logic [15:0]            wr_data,
  output logic [3:0]             rd_idx
);
  // ************************************************************
  // Bus tasks, entered and left one nanosecond after a rising edge
  // ************************************************************
  initial begin
    {cmd_valid, div_signed, div_long, wr_en} = 4'h0;
    cmd_op = dsd_pkg::DSD_OP_NONE;
    {src_idx, dst_idx, shift_amount, wr_idx, rd_idx} = 20'h00000;
    {divisor_source_register, dividend_register_pair} = 8'h00;
    wr_data = 16'h0000;
  end
  task automatic wr(input logic [3:0] i, input logic [15:0] d);
    wr_idx = i;
    wr_data = d;
    wr_en = 1'b1;
    @(posedge clock) #1 wr_en = 1'b0;
    // An idle edge keeps a following write from raising the strobe in the same step.
    @(posedge clock) #1;
  endtask : wr
  // Read data is registered, so it is taken one edge after the index.
  task automatic rd(input logic [3:0] i, output logic [15:0] d);
    rd_idx = i;
    @(posedge clock) #1 d = rd_data;
  endtask : rd
  // Issues one command and returns the edges until done was seen.
  task automatic cmd(input dsd_pkg::dsd_op_t op, input logic sg, input logic lg,
                     input logic [3:0] s, input logic [3:0] a, output int n);
    cmd_op = op;
    {div_signed, div_long} = {sg, lg};
    {src_idx, dst_idx, shift_amount} = {s, s + 4'h1, a};
    {divisor_source_register, dividend_register_pair} = {4'h9, s};
    cmd_valid = 1'b1;
    @(posedge clock) #1 cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge clock) #1 n++;
    end
  endtask : cmd
endmodule : dsd_dec_model

// ---- dsd_pkg.sv ----
// Shared constants and types of the divide and shift datapath.
package dsd_pkg;
  // ************************************************************
  // Widths and register file
  // ************************************************************
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned REG_CNT  = 16;
  localparam int unsigned IDX_W    = 4;
  localparam int unsigned SHAMT_W  = 4;
  localparam logic [3:0]  QUOT_IDX = 4'h0;
  localparam logic [3:0]  REM_IDX  = 4'h1;
  localparam logic [15:0] REG_RST  = 16'h0000;
  // One iteration per divisor bit.
  localparam logic [4:0]  DIV_ITERS = 5'h10;

  // ************************************************************
  // Operation codes
  // ************************************************************
  typedef enum logic [2:0] {
    DSD_OP_NONE,
    DSD_OP_ARITH_RIGHT_SHIFT,
    DSD_OP_LEFT_SHIFT,
    DSD_OP_LOGICAL_RIGHT_SHIFT,
    DSD_OP_DIV
  } dsd_op_t;
endpackage : dsd_pkg

// ---- dsd_shift_if.sv ----
// Interface joining the datapath to its shifter.
`timescale 1ns/1ps
interface dsd_shift_if;
  logic [15:0]         src;
  logic [3:0]          amount;
  dsd_pkg::dsd_op_t    op;
  logic [15:0]         result;
  modport user (output src, output amount, output op, input result);
  modport unit (input src, input amount, input op, output result);
endinterface : dsd_shift_if

// ---- dsd_shifter.sv ----
// Single-cycle barrel shifter of up to fifteen positions.
`timescale 1ns/1ps
module dsd_shifter (
  // Shift request and result
  dsd_shift_if.unit sh
);
  always_comb begin
    case (sh.op)
      dsd_pkg::DSD_OP_ARITH_RIGHT_SHIFT: begin
        sh.result = 16'($signed(sh.src) >>> sh.amount);
      end
      dsd_pkg::DSD_OP_LEFT_SHIFT: begin
        sh.result = sh.src << sh.amount;
      end
      dsd_pkg::DSD_OP_LOGICAL_RIGHT_SHIFT: begin
        sh.result = sh.src >> sh.amount;
      end
      default: begin
        sh.result = sh.src;
      end
    endcase
  end
endmodule : dsd_shifter
